// ---- logic/rmc_pkg.sv ----
// package of constants, modes and carriers for the radio mode controller
package rmc_pkg;
	// system clock period
	localparam int unsigned CLK_PERIOD_NS = 25;
	// powerdown_to_standby_delay, least time
	localparam int unsigned T_PD2SB_NS = 1000;
	// standby_to_active_delay, also the direct tx/rx turnaround
	localparam int unsigned T_STBY2A_NS = 130000;
	// least persistence of the in-channel power detector
	localparam int unsigned T_RPD_NS = 40000;
	// longest stretch in transmit, synthesizer is open loop there
	localparam int unsigned T_TXMAX_NS = 4000000;
	// least times round up, longest times round down
	localparam int unsigned PD2SB_CYC = (T_PD2SB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STBY2A_CYC = (T_STBY2A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RPD_CYC = (T_RPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TXMAX_CYC = T_TXMAX_NS / CLK_PERIOD_NS;
	// counter widths
	localparam int unsigned CNT_W = 18;
	localparam int unsigned RPD_W = 11;
	// air_rate_select field codes
	localparam logic [1:0] RATE_SEL_1M = 2'h0;
	localparam logic [1:0] RATE_SEL_2M = 2'h1;
	localparam logic [1:0] RATE_SEL_250K = 2'h2;
	// operating modes, settling states included
	typedef enum logic [2:0] {
		MODE_PDOWN, MODE_WAKE, MODE_STBY1, MODE_STBY2,
		MODE_RXSET, MODE_TXSET, MODE_RX, MODE_TX
	} rmc_mode_e;
	// air data rate in use
	typedef enum logic [1:0] {AIR_1M, AIR_2M, AIR_250K} rmc_rate_e;
	typedef logic [CNT_W-1:0] rmc_cnt_t;
	// control bits from the host
	typedef struct packed {
		logic power_up_bit;
		logic primary_receive_select;
		logic chip_enable;
		logic select_n;
		logic auto_protocol_enable;
	} rmc_ctrl_s;
	// events and levels from the baseband engine
	typedef struct packed {
		logic tx_fifo_empty;
		logic tx_done;
		logic rx_packet_ok;
		logic rx_fifo_full;
		logic proto_switch;
	} rmc_bb_s;
	// status towards the host
	typedef struct packed {
		rmc_mode_e mode;
		logic received_power_flag;
		logic clk_buffers_on;
		logic synth_on;
		logic config_lost;
		logic spi_ready;
	} rmc_stat_s;
endpackage

// ---- logic/rmc_power_filter.sv ----
// received-power detector synchroniser and persistence filter
`timescale 1ns/10ps
module rmc_power_filter (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic enable,
	input wire logic detect_raw,
	output logic detect_ok
);
	// whole state of the filter
	typedef struct packed {
		logic sync1; // first stage, read only by sync2
		logic sync2;
		logic [rmc_pkg::RPD_W-1:0] run; // cycles of unbroken detection
		logic ok;
	} rmc_filt_s;

	rmc_filt_s r_reg;
	rmc_filt_s r_next;

	// count unbroken detection, drop at once on any gap or when disabled
	always_comb begin
		r_next = r_reg;
		r_next.sync1 = detect_raw;
		r_next.sync2 = r_reg.sync1;
		if (!enable || !r_reg.sync2) begin
			r_next.run = '0;
			r_next.ok = 1'b0;
		end else if (r_reg.run == rmc_pkg::RPD_W'(rmc_pkg::RPD_CYC - 1)) begin
			r_next.ok = 1'b1;
		end else begin
			r_next.run = r_reg.run + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign detect_ok = r_reg.ok;

	persist_len_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$rose(r_reg.ok) |-> $past(r_reg.sync2) && $past(enable)
			&& ($past(r_reg.run) == rmc_pkg::RPD_W'(rmc_pkg::RPD_CYC - 1)))
		else $error("power flag rose before full persistence");
endmodule

// ---- logic/rmc_mode_ctrl.sv ----
// operating-mode controller of the packet radio
`timescale 1ns/10ps
module rmc_mode_ctrl #(
	parameter int unsigned STBY2A_CYC = rmc_pkg::STBY2A_CYC, // settle, shorten in simulation
	parameter int unsigned TXMAX_CYC = rmc_pkg::TXMAX_CYC // transmit stretch limit
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire rmc_pkg::rmc_ctrl_s ctl,
	input wire rmc_pkg::rmc_bb_s bb,
	input wire logic xo_running,
	input wire logic regs_lost,
	input wire logic reconfig_done,
	input wire logic [1:0] air_rate_select,
	input wire logic detect_raw,
	output logic rx_store,
	output logic rx_drop,
	output logic tx_limit_hit,
	output rmc_pkg::rmc_rate_e air_rate,
	output rmc_pkg::rmc_stat_s stat
);
	// whole state of the controller
	typedef struct packed {
		rmc_pkg::rmc_mode_e mode;
		rmc_pkg::rmc_cnt_t cnt; // settling time counter
		rmc_pkg::rmc_cnt_t tx_run; // cycles spent in transmit this stretch
		logic ce_prev; // enable one cycle ago, for the falling edge
		logic cfg_lost; // registers lost, active modes barred
		logic rpd_flag;
		logic rpd_frozen; // flag latched until next receive entry
		logic rx_store;
		logic rx_drop;
		logic tx_limit;
		rmc_pkg::rmc_rate_e rate;
		logic buf_on; // clock buffers running
		logic synth; // synthesizer keyed
		logic spi_ok; // host access open
	} rmc_ctl_s;

	rmc_ctl_s r_reg;
	rmc_ctl_s r_next;
	logic rpd_live; // filtered detector, valid only in receive

	// settle counter has reached its last cycle
	function automatic logic rmc_settled(input rmc_pkg::rmc_cnt_t cnt,
		input int unsigned lim);
		rmc_settled = (cnt == rmc_pkg::CNT_W'(lim - 1));
	endfunction

	// decode the rate field; a reserved code keeps the rate in use
	function automatic rmc_pkg::rmc_rate_e rmc_rate(input logic [1:0] sel,
		input rmc_pkg::rmc_rate_e keep);
		unique case (sel)
			rmc_pkg::RATE_SEL_1M: rmc_rate = rmc_pkg::AIR_1M;
			rmc_pkg::RATE_SEL_2M: rmc_rate = rmc_pkg::AIR_2M;
			rmc_pkg::RATE_SEL_250K: rmc_rate = rmc_pkg::AIR_250K;
			default: rmc_rate = keep;
		endcase
	endfunction

	// detector is only armed in receive, so the 130 us settle comes first
	rmc_power_filter u_filter (
		.clk_sys(clk_sys),
		.reset(reset),
		.enable(r_reg.mode == rmc_pkg::MODE_RX),
		.detect_raw(detect_raw),
		.detect_ok(rpd_live)
	);

	// mode sequencing and flags
	always_comb begin
		logic ce_fall;
		logic bar;
		ce_fall = r_reg.ce_prev & ~ctl.chip_enable;
		bar = r_reg.cfg_lost | regs_lost;
		r_next = r_reg;
		r_next.ce_prev = ctl.chip_enable;
		r_next.rx_store = 1'b0;
		r_next.rx_drop = 1'b0;
		r_next.tx_limit = 1'b0;
		// loss sets, host clears; a loss in the same cycle wins
		if (regs_lost) begin
			r_next.cfg_lost = 1'b1;
		end else if (reconfig_done) begin
			r_next.cfg_lost = 1'b0;
		end
		unique case (r_reg.mode)
			rmc_pkg::MODE_PDOWN: begin
				// the wake delay only holds with the oscillator running
				if (ctl.power_up_bit && xo_running) begin
					r_next.mode = rmc_pkg::MODE_WAKE;
					r_next.cnt = '0;
				end
			end
			rmc_pkg::MODE_WAKE: begin
				if (rmc_settled(r_reg.cnt, rmc_pkg::PD2SB_CYC)) begin
					r_next.mode = rmc_pkg::MODE_STBY1;
				end else begin
					r_next.cnt = r_reg.cnt + 1'b1;
				end
			end
			rmc_pkg::MODE_STBY1: begin
				// registers stay untouched here, host access stays open
				if (ctl.chip_enable && !bar) begin
					r_next.cnt = '0;
					if (ctl.primary_receive_select) begin
						r_next.mode = rmc_pkg::MODE_RXSET;
					end else if (!bb.tx_fifo_empty) begin
						r_next.mode = rmc_pkg::MODE_TXSET;
					end else begin
						r_next.mode = rmc_pkg::MODE_STBY2;
					end
				end
			end
			rmc_pkg::MODE_STBY2: begin
				r_next.cnt = '0;
				if (!ctl.chip_enable || bar) begin
					r_next.mode = rmc_pkg::MODE_STBY1;
				end else if (ctl.primary_receive_select) begin
					r_next.mode = rmc_pkg::MODE_RXSET;
				end else if (!bb.tx_fifo_empty && ctl.select_n) begin
					// wait for the upload to finish before keying the synthesizer
					r_next.mode = rmc_pkg::MODE_TXSET;
				end
			end
			rmc_pkg::MODE_RXSET: begin
				if (!ctl.chip_enable) begin
					r_next.mode = rmc_pkg::MODE_STBY1;
				end else if (rmc_settled(r_reg.cnt, STBY2A_CYC)) begin
					r_next.mode = rmc_pkg::MODE_RX;
				end else begin
					r_next.cnt = r_reg.cnt + 1'b1;
				end
			end
			rmc_pkg::MODE_TXSET: begin
				// enable may already be low: a pulse still sends one packet
				r_next.tx_run = '0;
				if (rmc_settled(r_reg.cnt, STBY2A_CYC)) begin
					r_next.mode = rmc_pkg::MODE_TX;
				end else begin
					r_next.cnt = r_reg.cnt + 1'b1;
				end
			end
			rmc_pkg::MODE_RX: begin
				// leave only on host request or protocol turnaround
				r_next.cnt = '0;
				if (!ctl.chip_enable) begin
					r_next.mode = rmc_pkg::MODE_STBY1;
				end else if (ctl.auto_protocol_enable && bb.proto_switch) begin
					r_next.mode = rmc_pkg::MODE_TXSET;
				end
			end
			rmc_pkg::MODE_TX: begin
				r_next.cnt = '0;
				r_next.tx_run = r_reg.tx_run + 1'b1;
				if (rmc_settled(r_reg.tx_run, TXMAX_CYC)) begin
					// cut the stretch: an open-loop synthesizer drifts off channel
					r_next.mode = rmc_pkg::MODE_STBY1;
					r_next.tx_limit = 1'b1;
				end else if (bb.tx_done) begin
					if (!ctl.chip_enable) begin
						r_next.mode = rmc_pkg::MODE_STBY1;
					end else if (ctl.auto_protocol_enable && bb.proto_switch) begin
						r_next.mode = rmc_pkg::MODE_RXSET;
					end else if (ctl.primary_receive_select) begin
						r_next.mode = rmc_pkg::MODE_RXSET;
					end else if (!bb.tx_fifo_empty) begin
						r_next.mode = rmc_pkg::MODE_TX;
					end else begin
						r_next.mode = rmc_pkg::MODE_STBY2;
					end
				end
			end
		endcase
		// power-down and register loss override every mode
		if (!ctl.power_up_bit || regs_lost) begin
			r_next.mode = rmc_pkg::MODE_PDOWN;
			r_next.cnt = '0;
		end
		// rate is picked up only while no packet is on air
		if (r_next.mode != rmc_pkg::MODE_RX && r_next.mode != rmc_pkg::MODE_TX) begin
			r_next.rate = rmc_rate(air_rate_select, r_reg.rate);
		end
		// status decode is registered so that every output leaves on a flop
		r_next.buf_on = r_next.mode inside {rmc_pkg::MODE_STBY2, rmc_pkg::MODE_RXSET,
			rmc_pkg::MODE_TXSET, rmc_pkg::MODE_RX, rmc_pkg::MODE_TX};
		r_next.synth = r_next.mode inside {rmc_pkg::MODE_RXSET, rmc_pkg::MODE_TXSET,
			rmc_pkg::MODE_RX, rmc_pkg::MODE_TX};
		r_next.spi_ok = 1'b1;
		// receive path: store or drop a validated packet
		if (r_reg.mode == rmc_pkg::MODE_RX && bb.rx_packet_ok) begin
			r_next.rx_store = ~bb.rx_fifo_full;
			r_next.rx_drop = bb.rx_fifo_full;
		end
		// power flag tracks the filter until a packet or enable fall latches it
		if (r_reg.mode == rmc_pkg::MODE_RXSET) begin
			r_next.rpd_frozen = 1'b0;
		end else if (r_reg.mode == rmc_pkg::MODE_RX && !r_reg.rpd_frozen) begin
			r_next.rpd_flag = rpd_live;
			if (bb.rx_packet_ok || ce_fall) begin
				r_next.rpd_frozen = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r_reg.mode <= rmc_pkg::MODE_PDOWN;
			r_reg.cnt <= '0;
			r_reg.tx_run <= '0;
			r_reg.ce_prev <= 1'b0;
			r_reg.cfg_lost <= 1'b0;
			r_reg.rpd_flag <= 1'b0;
			r_reg.rpd_frozen <= 1'b0;
			r_reg.rx_store <= 1'b0;
			r_reg.rx_drop <= 1'b0;
			r_reg.tx_limit <= 1'b0;
			r_reg.rate <= rmc_pkg::AIR_1M;
			r_reg.buf_on <= 1'b0;
			r_reg.synth <= 1'b0;
			r_reg.spi_ok <= 1'b1; // host access stays open through reset
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from state flip-flops
	assign rx_store = r_reg.rx_store;
	assign rx_drop = r_reg.rx_drop;
	assign tx_limit_hit = r_reg.tx_limit;
	assign air_rate = r_reg.rate;
	assign stat.mode = r_reg.mode;
	assign stat.received_power_flag = r_reg.rpd_flag;
	// clock buffers run in clocked standby and beyond
	assign stat.clk_buffers_on = r_reg.buf_on;
	assign stat.synth_on = r_reg.synth;
	assign stat.config_lost = r_reg.cfg_lost;
	// host access is open in every mode, power down included
	assign stat.spi_ready = r_reg.spi_ok;

	// checks
	reset_pdown_a: assert property (
		@(posedge clk_sys) $fell(reset) |-> r_reg.mode == rmc_pkg::MODE_PDOWN)
		else $error("not in power down after reset");

	pu_low_pdown_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		!ctl.power_up_bit |=> r_reg.mode == rmc_pkg::MODE_PDOWN)
		else $error("power-up low did not reach power down");

	wake_len_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$past(r_reg.mode) == rmc_pkg::MODE_WAKE && r_reg.mode == rmc_pkg::MODE_STBY1
		|-> $past(r_reg.cnt) == rmc_pkg::CNT_W'(rmc_pkg::PD2SB_CYC - 1))
		else $error("wake delay wrong length");

	ce_low_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.mode inside {rmc_pkg::MODE_RX, rmc_pkg::MODE_RXSET}
		&& !ctl.chip_enable && ctl.power_up_bit && !regs_lost
		|=> r_reg.mode == rmc_pkg::MODE_STBY1)
		else $error("receive held without enable");

	stby2_entry_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_STBY1 && ctl.chip_enable && ctl.power_up_bit
		&& !ctl.primary_receive_select && bb.tx_fifo_empty && !r_reg.cfg_lost && !regs_lost
		|=> r_reg.mode == rmc_pkg::MODE_STBY2)
		else $error("clocked standby not entered");

	settle_len_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$past(r_reg.mode) inside {rmc_pkg::MODE_TXSET, rmc_pkg::MODE_RXSET}
		&& r_reg.mode inside {rmc_pkg::MODE_TX, rmc_pkg::MODE_RX}
		|-> $past(r_reg.cnt) == rmc_pkg::CNT_W'(STBY2A_CYC - 1))
		else $error("settling delay wrong length");

	rx_entry_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$rose(r_reg.mode == rmc_pkg::MODE_RXSET) && !$past(r_reg.mode == rmc_pkg::MODE_TX)
		&& !$past(ctl.auto_protocol_enable)
		|-> $past(ctl.power_up_bit && ctl.primary_receive_select && ctl.chip_enable))
		else $error("receive entered without its three bits");

	rx_full_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_RX && bb.rx_packet_ok
		|=> rx_drop == $past(bb.rx_fifo_full) && rx_store == !$past(bb.rx_fifo_full))
		else $error("receive store or drop wrong");

	tx_limit_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_TX |-> r_reg.tx_run < rmc_pkg::CNT_W'(TXMAX_CYC))
		else $error("transmit stretch over limit");

	select_gate_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_STBY2 && !ctl.select_n
		|=> r_reg.mode != rmc_pkg::MODE_TXSET)
		else $error("transmit started while select low");

	rpd_hold_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		r_reg.rpd_frozen && r_reg.mode != rmc_pkg::MODE_RXSET
		|=> $stable(r_reg.rpd_flag))
		else $error("latched power flag moved");

	rx_reach_c: cover property (@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_RX);
	tx_stby2_c: cover property (@(posedge clk_sys) disable iff (reset)
		r_reg.mode == rmc_pkg::MODE_TX ##1 r_reg.mode == rmc_pkg::MODE_STBY2);
	tx_cut_c: cover property (@(posedge clk_sys) disable iff (reset) r_reg.tx_limit);
	rx_drop_c: cover property (@(posedge clk_sys) disable iff (reset) r_reg.rx_drop);
endmodule

// ---- verification/rmc_bb_model.sv ----
// behavioural baseband partner: transmit fifo level and packet air time
`timescale 1ns/10ps
module rmc_bb_model #(
	parameter int unsigned PKT_CYC = 500 // air time of one packet, acks and retries included
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire rmc_pkg::rmc_mode_e mode,
	input wire logic load,
	input wire logic stall,
	output logic tx_fifo_empty,
	output logic tx_done
);
	logic [3:0] level_reg; // packets waiting in the transmit fifo
	int unsigned air_reg; // cycles spent on the packet on air
	logic done_now; // current packet ends at this edge
	assign tx_fifo_empty = (level_reg == 4'h0);
	// stall stretches a packet without end, so only the device's limit can cut it
	assign done_now = (mode == rmc_pkg::MODE_TX) && (level_reg != 4'h0) && !stall
		&& (air_reg == PKT_CYC - 1);
	// air time advances and the fifo drains only while the device transmits; loads raise the fifo level in any mode
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			level_reg <= 4'h0;
			air_reg <= 0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= done_now;
			level_reg <= level_reg + {3'h0, load} - {3'h0, done_now};
			air_reg <= (mode != rmc_pkg::MODE_TX || done_now) ? 0 : (stall ? air_reg : air_reg + 1);
		end
	end
endmodule

// ---- verification/rmc_mode_ctrl_test.sv ----
// self-checking bench of the radio mode controller
`timescale 1ns/10ps
module rmc_mode_ctrl_test;
	localparam int unsigned SETTLE = 20; // shortened rx/tx settling
	localparam int unsigned TXLIM = 2000; // shortened transmit stretch limit
	localparam int unsigned PKT = 500; // packet air time in the partner
	logic clk_sys, reset, xo_running, regs_lost, reconfig_done, detect_raw, load, stall;
	logic rx_ok, rx_full, proto, fifo_empty, tx_done, rx_store, rx_drop, tx_limit_hit;
	logic [1:0] air_rate_select; // rate code towards the device
	logic [3:0] rows [4]; // rate code beside the rate it should give
	rmc_pkg::rmc_ctrl_s ctl; // host control bits
	rmc_pkg::rmc_bb_s bb; // baseband events
	rmc_pkg::rmc_rate_e air_rate;
	rmc_pkg::rmc_stat_s stat;
	int miscompares, compares, n;
	assign bb = {fifo_empty, tx_done, rx_ok, rx_full, proto};
	rmc_mode_ctrl #(.STBY2A_CYC(SETTLE), .TXMAX_CYC(TXLIM)) dut (.clk_sys(clk_sys),
		.reset(reset), .ctl(ctl), .bb(bb), .xo_running(xo_running), .regs_lost(regs_lost),
		.reconfig_done(reconfig_done), .air_rate_select(air_rate_select),
		.detect_raw(detect_raw), .rx_store(rx_store), .rx_drop(rx_drop),
		.tx_limit_hit(tx_limit_hit), .air_rate(air_rate), .stat(stat));
	rmc_bb_model #(.PKT_CYC(PKT)) bbm (.clk_sys(clk_sys), .reset(reset), .mode(stat.mode),
		.load(load), .stall(stall), .tx_fifo_empty(fifo_empty), .tx_done(tx_done));
	// free-running system clock, 25 ns period
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// one compare, counted; a mismatch is reported at once
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic complete_run();
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// all driving and sampling happens at falling edges, away from the sampling edge
	task automatic step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	// bounded wait for a mode; running out ends the run as a failure
	task automatic wait_mode(input rmc_pkg::rmc_mode_e m, input int bound);
		for (int i = 0; i < bound && stat.mode !== m; i++) begin
			step(1);
		end
		if (stat.mode !== m) begin
			chk("mode_wait", 8'(stat.mode), 8'(m));
			complete_run();
		end
	endtask
	// expected status word; buffers and synthesizer follow the mode
	function automatic logic [7:0] st(input rmc_pkg::rmc_mode_e m, input logic f, input logic c);
		return {m, f, m >= rmc_pkg::MODE_STBY2, m >= rmc_pkg::MODE_RXSET, c, 1'b1};
	endfunction
	// main sequence
	initial begin
		rows = '{4'h5, 4'h0, 4'ha, 4'he}; // code 3 is reserved and keeps the last rate
		ctl = '0;
		ctl.select_n = 1'b1;
		{xo_running, regs_lost, reconfig_done, detect_raw, load, stall} = '0;
		{rx_ok, rx_full, proto, air_rate_select} = '0;
		miscompares = 0;
		compares = 0;
		reset = 1'b1;
		step(12);
		reset = 1'b0;
		chk("stat", stat, st(rmc_pkg::MODE_PDOWN, 1'b0, 1'b0));
		chk("rate", 8'(air_rate), 8'(rmc_pkg::AIR_1M));
		// power up waits for the crystal, then takes the fixed wake time
		ctl.power_up_bit = 1'b1;
		step(5);
		chk("stat", stat, st(rmc_pkg::MODE_PDOWN, 1'b0, 1'b0));
		xo_running = 1'b1;
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_WAKE, 1'b0, 1'b0));
		step(rmc_pkg::PD2SB_CYC - 1);
		chk("stat", stat, st(rmc_pkg::MODE_WAKE, 1'b0, 1'b0));
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_STBY1, 1'b0, 1'b0));
		for (int i = 0; i < 4; i++) begin
			air_rate_select = rows[i][3:2];
			step(1);
			chk("rate", 8'(air_rate), 8'(rows[i][1:0]));
		end
		// lost registers force power down and bar the active modes until reconfigured
		regs_lost = 1'b1;
		step(1);
		regs_lost = 1'b0;
		chk("stat", stat, st(rmc_pkg::MODE_PDOWN, 1'b0, 1'b1));
		wait_mode(rmc_pkg::MODE_STBY1, 50);
		ctl.primary_receive_select = 1'b1;
		ctl.chip_enable = 1'b1;
		step(3);
		chk("stat", stat, st(rmc_pkg::MODE_STBY1, 1'b0, 1'b1));
		reconfig_done = 1'b1;
		step(1);
		reconfig_done = 1'b0;
		wait_mode(rmc_pkg::MODE_RXSET, 3);
		chk("stat", stat, st(rmc_pkg::MODE_RXSET, 1'b0, 1'b0));
		step(SETTLE - 1);
		chk("stat", stat, st(rmc_pkg::MODE_RXSET, 1'b0, 1'b0));
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_RX, 1'b0, 1'b0));
		// power flag needs the full persistence; a turnaround request is ignored without auto
		detect_raw = 1'b1;
		proto = 1'b1;
		step(1);
		proto = 1'b0;
		step(1598);
		chk("stat", stat, st(rmc_pkg::MODE_RX, 1'b0, 1'b0));
		for (n = 0; n < 15 && stat.received_power_flag !== 1'b1; n++) begin
			step(1);
		end
		chk("flag", 8'(stat.received_power_flag), 8'h01);
		// drop when full, store when room, back to back
		for (int j = 0; j < 2; j++) begin
			rx_ok = 1'b1;
			rx_full = (j == 0);
			step(1);
			chk("rx_events", {6'h0, rx_store, rx_drop}, (j == 0) ? 8'h01 : 8'h02);
		end
		rx_ok = 1'b0;
		detect_raw = 1'b0;
		step(10);
		chk("flag", 8'(stat.received_power_flag), 8'h01);
		ctl.chip_enable = 1'b0;
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_STBY1, 1'b1, 1'b0));
		rx_ok = 1'b1;
		step(2);
		rx_ok = 1'b0;
		chk("rx_events", {6'h0, rx_store, rx_drop}, 8'h00);
		// single packet from an enable pulse longer than the host minimum
		ctl.primary_receive_select = 1'b0;
		load = 1'b1;
		step(1);
		load = 1'b0;
		ctl.chip_enable = 1'b1;
		wait_mode(rmc_pkg::MODE_TX, SETTLE + 3);
		step(380);
		ctl.chip_enable = 1'b0;
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_TX, 1'b1, 1'b0));
		wait_mode(rmc_pkg::MODE_STBY1, PKT);
		chk("fifo_empty", 8'(fifo_empty), 8'h01);
		// enable held: two packets drain back to back, then clocked standby
		load = 1'b1;
		step(2);
		load = 1'b0;
		ctl.chip_enable = 1'b1;
		for (n = 0; n < PKT + SETTLE + 5 && tx_done !== 1'b1; n++) begin
			step(1);
		end
		chk("tx_done", 8'(tx_done), 8'h01);
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_TX, 1'b1, 1'b0));
		wait_mode(rmc_pkg::MODE_STBY2, PKT + 2);
		chk("stat", stat, st(rmc_pkg::MODE_STBY2, 1'b1, 1'b0));
		// upload under select; sending starts only when select returns high
		ctl.select_n = 1'b0;
		load = 1'b1;
		stall = 1'b1;
		step(1);
		load = 1'b0;
		step(2);
		chk("stat", stat, st(rmc_pkg::MODE_STBY2, 1'b1, 1'b0));
		ctl.select_n = 1'b1;
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_TXSET, 1'b1, 1'b0));
		wait_mode(rmc_pkg::MODE_TX, SETTLE + 2);
		// stalled packet: the stretch limit must cut transmit
		ctl.chip_enable = 1'b0;
		for (n = 0; n < TXLIM + 10 && tx_limit_hit !== 1'b1; n++) begin
			step(1);
		end
		chk("tx_stretch", 8'(n + 5 > TXLIM && n <= TXLIM), 8'h01);
		chk("stat", stat, st(rmc_pkg::MODE_STBY1, 1'b1, 1'b0));
		stall = 1'b0;
		ctl.power_up_bit = 1'b0;
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_PDOWN, 1'b1, 1'b0));
		// reset again from standby: mode, flag and rate return to their reset values
		ctl.power_up_bit = 1'b1;
		wait_mode(rmc_pkg::MODE_STBY1, 50);
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		chk("stat", stat, st(rmc_pkg::MODE_PDOWN, 1'b0, 1'b0));
		chk("rate", 8'(air_rate), 8'(rmc_pkg::AIR_1M));
		step(1);
		chk("stat", stat, st(rmc_pkg::MODE_WAKE, 1'b0, 1'b0));
		chk("rate", 8'(air_rate), 8'(rmc_pkg::AIR_1M));
		// protocol turnaround from receive, then receive-select turns transmit around
		load = 1'b1;
		step(1);
		load = 1'b0;
		ctl.auto_protocol_enable = 1'b1;
		ctl.primary_receive_select = 1'b1;
		ctl.chip_enable = 1'b1;
		wait_mode(rmc_pkg::MODE_RX, rmc_pkg::PD2SB_CYC + SETTLE + 5);
		proto = 1'b1;
		step(1);
		proto = 1'b0;
		chk("stat", stat, st(rmc_pkg::MODE_TXSET, 1'b0, 1'b0));
		wait_mode(rmc_pkg::MODE_TX, SETTLE + 2);
		wait_mode(rmc_pkg::MODE_RXSET, PKT + 3);
		chk("stat", stat, st(rmc_pkg::MODE_RXSET, 1'b0, 1'b0));
		complete_run();
	end
endmodule
